// file: shared/mcil_pkg.sv
// shared constants and types for the motion command input logic
package mcil_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_DSEL0  = 8'h00;
  localparam logic [7:0] OFS_DSEL1  = 8'h04;
  localparam logic [7:0] OFS_HCFG   = 8'h08;
  localparam logic [7:0] OFS_HSPD   = 8'h0c;
  localparam logic [7:0] OFS_HSTART = 8'h10;
  localparam logic [7:0] OFS_HACC   = 8'h14;
  localparam logic [7:0] OFS_HOFS   = 8'h18;
  localparam logic [7:0] OFS_HCUR   = 8'h1c;
  localparam logic [7:0] OFS_ISTEP  = 8'h20;
  localparam logic [7:0] OFS_ISPD   = 8'h24;
  localparam logic [7:0] OFS_ISTART = 8'h28;
  localparam logic [7:0] OFS_IACC   = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_ALMCLR = 8'h34;
  // control word field positions
  localparam int F_HMODE   = 0;
  localparam int F_HDIR    = 2;
  localparam int F_SLOT    = 3;
  localparam int F_TIM     = 4;
  localparam int F_HALM    = 5;
  localparam int F_STOPACT = 6;
  localparam int F_EXDIR   = 8;
  localparam int F_EXNET   = 9;
  localparam int F_NETEXC  = 10;
  // reset values
  localparam logic [31:0] DSEL0_RST  = 32'h0302_0100;
  localparam logic [31:0] DSEL1_RST  = 32'h0000_0504;
  localparam logic [10:0] HCFG_RST   = 11'h145;
  localparam logic [19:0] SPD_RST    = 20'h003e8;
  localparam logic [19:0] START_RST  = 20'h001f4;
  localparam logic [19:0] ACC_RST    = 20'h003e8;
  localparam logic [23:0] OFS_RST    = 24'h000000;
  localparam logic [9:0]  CUR_RST    = 10'h3e8;
  localparam logic [22:0] ISTEP_RST  = 23'h000001;
  // stop action encodings (bit 1 set means current off)
  localparam logic [1:0] STOP_IMM = 2'h0;
  localparam logic [1:0] STOP_DEC = 2'h1;
  // command kinds issued to the motion engine
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_POS   = 3'b001,
    CMD_HOME  = 3'b010,
    CMD_RUN   = 3'b011,
    CMD_INCH  = 3'b100,
    CMD_DECEL = 3'b101,
    CMD_STOP  = 3'b110
  } mcil_kind_t;
  // block state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_POS   = 3'b001,
    ST_HOME  = 3'b010,
    ST_RUN   = 3'b011,
    ST_DECEL = 3'b100,
    ST_INCH  = 3'b101
  } mcil_state_t;
  // command to the motion engine
  typedef struct packed {
    mcil_kind_t kind;
    logic       dir;
    logic [5:0] data_no;
    logic [1:0] stop_act;
  } mcil_cmd_t;
  // homing settings
  typedef struct packed {
    logic [1:0]  mode;
    logic        dir;
    logic        slot_en;
    logic        tim_en;
    logic [19:0] spd;
    logic [19:0] start;
    logic [19:0] acc;
    logic [23:0] ofs;
    logic [9:0]  cur;
  } mcil_home_t;
  // inch settings
  typedef struct packed {
    logic [22:0] travel;
    logic [19:0] spd;
    logic [19:0] start;
    logic [19:0] acc;
  } mcil_inch_t;
  // command input pins
  typedef struct packed {
    logic [5:0] dstart;
    logic       home;
    logic       forward_run;
    logic       rev;
    logic       pinch;
    logic       minch;
    logic       stop;
    logic       exc;
    logic [5:0] sel;
    logic       slot;
    logic       tim;
  } mcil_pins_t;
endpackage

// file: design/mcil_top.sv
// motion command input logic: pin commands to motion engine requests
`timescale 1ns/1ps
module mcil_top (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic                     PREADY,
  output logic [31:0]              PRDATA,
  output logic                     PSLVERR,
  // command pins, asynchronous
  input  wire mcil_pkg::mcil_pins_t PINS,
  // motion engine, same clock
  input  wire logic                MOTION_DONE,
  output logic                     CMD_VALID,
  output mcil_pkg::mcil_cmd_t      CMD,
  output mcil_pkg::mcil_home_t     HOME_CFG,
  output mcil_pkg::mcil_inch_t     INCH_CFG,
  output logic                     SLOT_USE,
  output logic                     TIM_USE,
  // motor status
  output logic                     ORIGIN_OK,
  output logic                     ALARM,
  output logic                     EXCITE,
  output logic                     BRAKE_REL
);

  typedef struct packed {
    mcil_pkg::mcil_pins_t  s1;
    mcil_pkg::mcil_pins_t  s2;
    mcil_pkg::mcil_pins_t  prev;
    mcil_pkg::mcil_state_t st;
    logic [31:0]           dsel0;
    logic [31:0]           dsel1;
    logic [10:0]           hcfg;
    mcil_pkg::mcil_home_t  home;
    mcil_pkg::mcil_inch_t  inch;
    mcil_pkg::mcil_cmd_t   cmd;
    logic                  cmd_valid;
    logic                  run_dir;
    logic [5:0]            run_no;
    logic                  run_flag;
    logic                  origin;
    logic                  alarm;
    logic                  excite;
    logic                  brake;
    logic                  cur_off;
    logic                  slot_use;
    logic                  tim_use;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
  } mcil_regs_t;

  mcil_regs_t r_reg;
  mcil_regs_t r_next;
  mcil_pkg::mcil_pins_t rise;
  logic       exc_req;
  logic [5:0] ds_no;
  logic       run_ok;
  logic       start_ok;

  // operation data number mapped to direct start input i
  function automatic logic [5:0] dsel_no(input logic [31:0] d0,
                                         input logic [31:0] d1,
                                         input int          i);
    logic [63:0] all;
    all = {d1, d0};
    dsel_no = all[i*8 +: 6];
  endfunction

  // one command word
  function automatic mcil_pkg::mcil_cmd_t mk_cmd(
      input mcil_pkg::mcil_kind_t k, input logic dir,
      input logic [5:0] no, input logic [1:0] act);
    mk_cmd = '{kind: k, dir: dir, data_no: no, stop_act: act};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // edge from synchronised copies
  assign rise = r_reg.s2 & ~r_reg.prev;

  assign exc_req = (~r_reg.hcfg[mcil_pkg::F_EXDIR] | r_reg.s2.exc) &
                   (~r_reg.hcfg[mcil_pkg::F_EXNET] |
                    r_reg.hcfg[mcil_pkg::F_NETEXC]);

  // starts need a live motor, no alarm and no held stop
  assign start_ok = r_reg.excite & ~r_reg.alarm & ~r_reg.s2.stop;

  // run direction input alone, no conflict
  assign run_ok = r_reg.run_dir ? (r_reg.s2.forward_run & ~r_reg.s2.rev)
                                : (r_reg.s2.rev & ~r_reg.s2.forward_run);

  // lowest numbered direct start wins on a tie
  always_comb
  begin
    ds_no = '0;
    for (int i = 5; i >= 0; i--)
    begin
      if (rise.dstart[i])
        ds_no = dsel_no(r_reg.dsel0, r_reg.dsel1, i);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic acc1;
    logic acc2;
    logic hit;
    logic [31:0] rd;
    r_next = r_reg;
    acc1 = PSEL & PENABLE & ~r_reg.pready;
    acc2 = PSEL & PENABLE & r_reg.pready;
    hit = 1'b1;
    rd = '0;
    r_next.cmd_valid = 1'b0;
    r_next.s1 = PINS;
    r_next.s2 = r_reg.s1;
    r_next.prev = r_reg.s2;

    // register read mux, unmapped gives slave error
    case (PADDR)
      mcil_pkg::OFS_DSEL0:  rd = r_reg.dsel0;
      mcil_pkg::OFS_DSEL1:  rd = r_reg.dsel1;
      mcil_pkg::OFS_HCFG:   rd = {21'h0, r_reg.hcfg};
      mcil_pkg::OFS_HSPD:   rd = {12'h0, r_reg.home.spd};
      mcil_pkg::OFS_HSTART: rd = {12'h0, r_reg.home.start};
      mcil_pkg::OFS_HACC:   rd = {12'h0, r_reg.home.acc};
      mcil_pkg::OFS_HOFS:   rd = {{8{r_reg.home.ofs[23]}}, r_reg.home.ofs};
      mcil_pkg::OFS_HCUR:   rd = {22'h0, r_reg.home.cur};
      mcil_pkg::OFS_ISTEP:  rd = {9'h0, r_reg.inch.travel};
      mcil_pkg::OFS_ISPD:   rd = {12'h0, r_reg.inch.spd};
      mcil_pkg::OFS_ISTART: rd = {12'h0, r_reg.inch.start};
      mcil_pkg::OFS_IACC:   rd = {12'h0, r_reg.inch.acc};
      mcil_pkg::OFS_STATUS: rd = {18'h0, r_reg.run_no, r_reg.cur_off,
                                  r_reg.brake, r_reg.excite, r_reg.alarm,
                                  r_reg.origin, r_reg.st};
      mcil_pkg::OFS_ALMCLR: rd = '0;
      default:              hit = 1'b0;
    endcase

    // two cycle access: data staged first, write at the ready edge
    r_next.pready = acc1;
    if (acc1)
    begin
      r_next.prdata = rd;
      r_next.pslverr = ~hit;
    end
    if (acc2 & PWRITE & hit)
    begin
      case (PADDR)
        mcil_pkg::OFS_DSEL0:  r_next.dsel0 = PWDATA & 32'h3f3f_3f3f;
        mcil_pkg::OFS_DSEL1:  r_next.dsel1 = PWDATA & 32'h0000_3f3f;
        mcil_pkg::OFS_HCFG:   r_next.hcfg = PWDATA[10:0];
        mcil_pkg::OFS_HSPD:   r_next.home.spd = PWDATA[19:0];
        mcil_pkg::OFS_HSTART: r_next.home.start = PWDATA[19:0];
        mcil_pkg::OFS_HACC:   r_next.home.acc = PWDATA[19:0];
        mcil_pkg::OFS_HOFS:   r_next.home.ofs = PWDATA[23:0];
        mcil_pkg::OFS_HCUR:   r_next.home.cur = PWDATA[9:0];
        mcil_pkg::OFS_ISTEP:  r_next.inch.travel = PWDATA[22:0];
        mcil_pkg::OFS_ISPD:   r_next.inch.spd = PWDATA[19:0];
        mcil_pkg::OFS_ISTART: r_next.inch.start = PWDATA[19:0];
        mcil_pkg::OFS_IACC:   r_next.inch.acc = PWDATA[19:0];
        mcil_pkg::OFS_ALMCLR:
          if (PWDATA[0])
            r_next.alarm = 1'b0;
        default: ;
      endcase
    end

    // mode, direction and sensor enables from the control word
    r_next.home.mode = r_next.hcfg[mcil_pkg::F_HMODE +: 2];
    r_next.home.dir = r_next.hcfg[mcil_pkg::F_HDIR];
    r_next.home.slot_en = r_next.hcfg[mcil_pkg::F_SLOT];
    r_next.home.tim_en = r_next.hcfg[mcil_pkg::F_TIM];

    // sensors reach the engine only while homing with enable
    r_next.slot_use = r_reg.s2.slot & r_reg.home.slot_en &
                      (r_reg.st == mcil_pkg::ST_HOME);
    r_next.tim_use = r_reg.s2.tim & r_reg.home.tim_en &
                     (r_reg.st == mcil_pkg::ST_HOME);

    // winding drive follows the request; current off holds it down
    if (!exc_req)
      r_next.cur_off = 1'b0;
    r_next.excite = exc_req & ~r_reg.cur_off;
    r_next.brake = r_reg.excite & r_next.excite;

    // command sequencing
    case (r_reg.st)
      mcil_pkg::ST_IDLE:
        if (start_ok)
        begin
          if (rise.home)
          begin
            // start homing, origin lost until done
            r_next.cmd = mk_cmd(mcil_pkg::CMD_HOME, r_reg.home.dir,
                                '0, '0);
            r_next.cmd_valid = 1'b1;
            r_next.origin = 1'b0;
            r_next.st = mcil_pkg::ST_HOME;
          end
          else if (|rise.dstart)
          begin
            // refuse the move and raise the alarm
            if (r_reg.hcfg[mcil_pkg::F_HALM] && !r_reg.origin)
              r_next.alarm = 1'b1;
            else
            begin
              r_next.cmd = mk_cmd(mcil_pkg::CMD_POS, 1'b1, ds_no, '0);
              r_next.cmd_valid = 1'b1;
              r_next.st = mcil_pkg::ST_POS;
            end
          end
          else if (rise.pinch ^ rise.minch)
          begin
            // one inch in the requested direction
            r_next.cmd = mk_cmd(mcil_pkg::CMD_INCH, rise.pinch, '0, '0);
            r_next.cmd_valid = 1'b1;
            r_next.st = mcil_pkg::ST_INCH;
          end
          else if (r_reg.s2.forward_run ^ r_reg.s2.rev)
          begin
            // level run at the selected data speed
            r_next.cmd = mk_cmd(mcil_pkg::CMD_RUN, r_reg.s2.forward_run,
                                r_reg.s2.sel, '0);
            r_next.cmd_valid = 1'b1;
            r_next.run_dir = r_reg.s2.forward_run;
            r_next.run_no = r_reg.s2.sel;
            r_next.run_flag = 1'b1;
            r_next.st = mcil_pkg::ST_RUN;
          end
        end
      mcil_pkg::ST_RUN:
        if (!run_ok)
        begin
          r_next.cmd = mk_cmd(mcil_pkg::CMD_DECEL, r_reg.run_dir,
                              r_reg.run_no, '0);
          r_next.cmd_valid = 1'b1;
          r_next.st = mcil_pkg::ST_DECEL;
        end
        else if (r_reg.s2.sel != r_reg.run_no)
        begin
          // speed follows the new data number
          r_next.cmd = mk_cmd(mcil_pkg::CMD_RUN, r_reg.run_dir,
                              r_reg.s2.sel, '0);
          r_next.cmd_valid = 1'b1;
          r_next.run_no = r_reg.s2.sel;
        end
      mcil_pkg::ST_DECEL:
        if (MOTION_DONE)
        begin
          r_next.run_flag = 1'b0;
          r_next.st = mcil_pkg::ST_IDLE;
        end
        else if (r_reg.run_flag && run_ok && !r_reg.s2.stop)
        begin
          r_next.cmd = mk_cmd(mcil_pkg::CMD_RUN, r_reg.run_dir,
                              r_reg.s2.sel, '0);
          r_next.cmd_valid = 1'b1;
          r_next.run_no = r_reg.s2.sel;
          r_next.st = mcil_pkg::ST_RUN;
        end
      mcil_pkg::ST_POS, mcil_pkg::ST_INCH:
        if (MOTION_DONE)
          r_next.st = mcil_pkg::ST_IDLE;
      mcil_pkg::ST_HOME:
        if (MOTION_DONE)
        begin
          // origin once homing ends and motor stops
          r_next.origin = 1'b1;
          r_next.st = mcil_pkg::ST_IDLE;
        end
      default:
        r_next.st = mcil_pkg::ST_IDLE;
    endcase

    // stop overrides any motion, travel discarded by engine
    if (rise.stop && r_reg.st != mcil_pkg::ST_IDLE)
    begin
      r_next.cmd = mk_cmd(mcil_pkg::CMD_STOP, r_reg.cmd.dir,
                          r_reg.cmd.data_no,
                          r_reg.hcfg[mcil_pkg::F_STOPACT +: 2]);
      r_next.cmd_valid = 1'b1;
      r_next.run_flag = 1'b0;
      r_next.st = mcil_pkg::ST_DECEL;
      if (r_reg.hcfg[mcil_pkg::F_STOPACT + 1])
        r_next.cur_off = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register, constants only under reset
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      r_reg <= '0;
      r_reg.dsel0 <= mcil_pkg::DSEL0_RST;
      r_reg.dsel1 <= mcil_pkg::DSEL1_RST;
      r_reg.hcfg <= mcil_pkg::HCFG_RST;
      r_reg.home <= '{mode: 2'h1, dir: 1'b1, slot_en: 1'b0, tim_en: 1'b0,
                      spd: mcil_pkg::SPD_RST, start: mcil_pkg::START_RST,
                      acc: mcil_pkg::ACC_RST, ofs: mcil_pkg::OFS_RST,
                      cur: mcil_pkg::CUR_RST};
      r_reg.inch <= '{travel: mcil_pkg::ISTEP_RST, spd: mcil_pkg::SPD_RST,
                      start: mcil_pkg::START_RST, acc: mcil_pkg::ACC_RST};
    end
    else
      r_reg <= r_next;
  end

  // outputs straight from flops
  assign PREADY    = r_reg.pready;
  assign PRDATA    = r_reg.prdata;
  assign PSLVERR   = r_reg.pslverr;
  assign CMD_VALID = r_reg.cmd_valid;
  assign CMD       = r_reg.cmd;
  assign HOME_CFG  = r_reg.home;
  assign INCH_CFG  = r_reg.inch;
  assign SLOT_USE  = r_reg.slot_use;
  assign TIM_USE   = r_reg.tim_use;
  assign ORIGIN_OK = r_reg.origin;
  assign ALARM     = r_reg.alarm;
  assign EXCITE    = r_reg.excite;
  assign BRAKE_REL = r_reg.brake;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_dstart;
    r_reg.st == mcil_pkg::ST_IDLE && start_ok && !rise.home &&
    rise.dstart[0] && !r_reg.hcfg[mcil_pkg::F_HALM] |=>
    r_reg.cmd_valid && r_reg.cmd.kind == mcil_pkg::CMD_POS &&
    r_reg.cmd.data_no == $past(r_reg.dsel0[5:0]);
  endproperty
  a_dstart: assert property (p_dstart) else $error("direct start lost");

  property p_halm;
    r_reg.st == mcil_pkg::ST_IDLE && start_ok && !rise.home &&
    |rise.dstart && r_reg.hcfg[mcil_pkg::F_HALM] && !r_reg.origin |=>
    r_reg.alarm && !r_reg.cmd_valid && r_reg.st == mcil_pkg::ST_IDLE;
  endproperty
  a_halm: assert property (p_halm) else $error("homing alarm missed");

  property p_home;
    r_reg.st == mcil_pkg::ST_HOME && MOTION_DONE && !rise.stop |=>
    r_reg.origin ##1 r_reg.origin;
  endproperty
  a_home: assert property (p_home) else $error("origin not set");

  property p_both;
    r_reg.st == mcil_pkg::ST_RUN && r_reg.s2.forward_run && r_reg.s2.rev &&
    !rise.stop |=> r_reg.cmd.kind == mcil_pkg::CMD_DECEL &&
    r_reg.st == mcil_pkg::ST_DECEL;
  endproperty
  a_both: assert property (p_both) else $error("no decel on conflict");

  property p_reacc;
    r_reg.st == mcil_pkg::ST_DECEL && r_reg.run_flag && run_ok &&
    !MOTION_DONE && !r_reg.s2.stop && !rise.stop |=>
    r_reg.cmd.kind == mcil_pkg::CMD_RUN && r_reg.st == mcil_pkg::ST_RUN;
  endproperty
  a_reacc: assert property (p_reacc) else $error("no reacceleration");

  property p_speed;
    r_reg.st == mcil_pkg::ST_RUN && run_ok && !rise.stop &&
    r_reg.s2.sel != r_reg.run_no |=> r_reg.cmd_valid &&
    r_reg.cmd.data_no == $past(r_reg.s2.sel);
  endproperty
  a_speed: assert property (p_speed) else $error("speed not updated");

  property p_stop;
    r_reg.st != mcil_pkg::ST_IDLE && rise.stop |=>
    r_reg.cmd.kind == mcil_pkg::CMD_STOP &&
    r_reg.cmd.stop_act == $past(r_reg.hcfg[mcil_pkg::F_STOPACT +: 2]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not issued");

  property p_curoff;
    r_reg.st != mcil_pkg::ST_IDLE && rise.stop &&
    r_reg.hcfg[mcil_pkg::F_STOPACT + 1] |=>
    ##1 !r_reg.excite;
  endproperty
  a_curoff: assert property (p_curoff) else $error("current stayed on");

  property p_brake;
    r_reg.brake |-> r_reg.excite && $past(r_reg.excite);
  endproperty
  a_brake: assert property (p_brake) else $error("brake before excite");

  property p_exc;
    !r_reg.hcfg[mcil_pkg::F_EXDIR] && !r_reg.hcfg[mcil_pkg::F_EXNET] &&
    !r_reg.cur_off |=> r_reg.excite;
  endproperty
  a_exc: assert property (p_exc) else $error("unmapped excite not on");
endmodule

// file: verif/mcil_engine.sv
// motion engine stand-in: answers each finite command with a done pulse
`timescale 1ns/1ps
module mcil_engine (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // command from the block
  input  wire logic                cmd_valid,
  input  wire mcil_pkg::mcil_cmd_t cmd,
  // length of a move in cycles, prompt or slow
  input  wire logic [7:0]          dly,
  // motion finished, motor stopped
  output logic                     done
);
  logic [7:0] cnt;

  // a new command replaces the old one, so a stop restarts the count at dly
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt  <= 8'h00;
      done <= 1'h0;
    end
    else
    begin
      done <= (cnt == 8'h01);
      if (cmd_valid)
        cnt <= (cmd.kind == mcil_pkg::CMD_RUN) ? 8'h00 : dly;
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
  end
endmodule

// file: verif/mcil_top_bench.sv
// self-checking bench for the motion command input logic
`timescale 1ns/1ps
module mcil_top_bench;
  localparam logic [98:0] HOME_DEF = {2'h1, 1'h1, 2'h0, 20'h003e8,
    20'h001f4, 20'h003e8, 24'h000000, 10'h3e8};
  localparam logic [82:0] INCH_DEF = {23'h000001, 20'h003e8, 20'h001f4,
    20'h003e8};
  logic                 clk;
  logic                 rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  mcil_pkg::mcil_pins_t pins;
  logic                 done;
  logic                 cmd_valid;
  mcil_pkg::mcil_cmd_t  cmd;
  mcil_pkg::mcil_home_t home_cfg;
  mcil_pkg::mcil_inch_t inch_cfg;
  logic                 slot_use;
  logic                 tim_use;
  logic                 origin_ok;
  logic                 alarm;
  logic                 excite;
  logic                 brake_rel;
  logic [7:0]           dly;
  logic [31:0]          rdata;
  logic                 rerr;
  logic [15:0]          seed;
  logic [47:0]          nums;
  logic [5:0]           s;
  logic [12:0]          map_tab [4];
  int                   n_mismatch;
  int                   comparisons;
  int                   ncmd;
  int                   k;

  mcil_top dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .PINS(pins), .MOTION_DONE(done),
    .CMD_VALID(cmd_valid), .CMD(cmd), .HOME_CFG(home_cfg),
    .INCH_CFG(inch_cfg), .SLOT_USE(slot_use), .TIM_USE(tim_use),
    .ORIGIN_OK(origin_ok), .ALARM(alarm), .EXCITE(excite),
    .BRAKE_REL(brake_rel));
  mcil_engine eng_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .dly(dly), .done(done));

  ////////////////////////////////////////////////////////////////////////
  // clock, command counter and watchdog
  always #20 clk = ~clk;
  always @(posedge clk)
    if (cmd_valid === 1'h1)
      ncmd++;
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'h1)
      n_mismatch++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("rdata", 128'(e), 128'(rdata));
  endtask
  // wait for a command, compare its kind and the masked fields
  task automatic wcmd(input logic [2:0] kd, input logic [8:0] m,
                      input logic [8:0] e);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (cmd_valid !== 1'h1 && n < 40);
    if (cmd_valid !== 1'h1)
      n_mismatch++;
    chk("cmd_kind", 128'(kd), 128'(cmd.kind));
    chk("cmd_fields", 128'(e & m),
        128'({cmd.dir, cmd.data_no, cmd.stop_act} & m));
  endtask
  task automatic till_done();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (done !== 1'h1 && n < 200);
    if (done !== 1'h1)
      n_mismatch++;
    repeat (2) @(posedge clk);
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pins = '0;
    dly = 8'h03;
    seed = 16'h0063;
    map_tab = '{13'h1045, 13'h0745, 13'h0b45, 13'h1f45};
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rd(mcil_pkg::OFS_DSEL0, 32'h0302_0100);
    rd(mcil_pkg::OFS_DSEL1, 32'h0000_0504);
    rd(mcil_pkg::OFS_HCFG, 32'h0000_0145);
    chk("home_cfg", 128'(HOME_DEF), 128'(home_cfg));
    chk("inch_cfg", 128'(INCH_DEF), 128'(inch_cfg));
    apb(1'h0, 8'h3c, 32'h0);
    chk("slverr", 128'(1'h1), 128'(rerr));
    apb(1'h1, mcil_pkg::OFS_HSPD, {12'h000, seed, seed[3:0]});
    repeat (2) @(posedge clk);
    chk("home_spd", 128'({seed, seed[3:0]}), 128'(home_cfg.spd));
    apb(1'h1, mcil_pkg::OFS_HOFS, 32'h0080_0000);
    rd(mcil_pkg::OFS_HOFS, 32'hff80_0000);
    // largest inch travel and zero push current
    apb(1'h1, mcil_pkg::OFS_ISTEP, 32'h007f_ffff);
    rd(mcil_pkg::OFS_ISTEP, 32'h007f_ffff);
    apb(1'h1, mcil_pkg::OFS_HCUR, 32'h0000_0000);
    rd(mcil_pkg::OFS_HCUR, 32'h0000_0000);
    // excitation first, brake one step behind
    pins.exc <= 1'h1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (excite !== 1'h1 && k < 20);
    chk("brake_rel", 128'(1'h0), 128'(brake_rel));
    @(posedge clk);
    chk("brake_rel", 128'(1'h1), 128'(brake_rel));
    foreach (map_tab[i])
    begin
      pins.exc <= map_tab[i][11];
      apb(1'h1, mcil_pkg::OFS_HCFG, 32'(map_tab[i][10:0]));
      repeat (6) @(posedge clk);
      chk("excite", 128'(map_tab[i][12]), 128'(excite));
    end
    apb(1'h1, mcil_pkg::OFS_HCFG, 32'h145);
    // direct starts with random mapped numbers, top lane at 63
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      nums[i*8 +: 8] = {2'h0, seed[5:0]};
    end
    nums[45:40] = 6'h3f;
    apb(1'h1, mcil_pkg::OFS_DSEL0, nums[31:0]);
    apb(1'h1, mcil_pkg::OFS_DSEL1, {16'h0, nums[47:32]});
    for (int i = 0; i < 6; i++)
    begin
      pins.dstart[i] <= 1'h1;
      wcmd(mcil_pkg::CMD_POS, 9'h0fc, {1'h0, nums[i*8 +: 6], 2'h0});
      pins.dstart[i] <= 1'h0;
      till_done();
    end
    // start without origin while the alarm is enabled
    apb(1'h1, mcil_pkg::OFS_HCFG, 32'h165);
    k = ncmd;
    pins.dstart[0] <= 1'h1;
    repeat (8) @(posedge clk);
    pins.dstart[0] <= 1'h0;
    chk("alarm", 128'(1'h1), 128'(alarm));
    chk("no_cmd", 128'(k), 128'(ncmd));
    // idle, no origin, alarm, excited, brake released
    rd(mcil_pkg::OFS_STATUS, 32'h0000_0070);
    apb(1'h1, mcil_pkg::OFS_ALMCLR, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      apb(1'h1, mcil_pkg::OFS_HCFG, 32'h15c | 32'(m));
      repeat (2) @(posedge clk);
      chk("home_mode", 128'(m), 128'(home_cfg.mode));
    end
    apb(1'h1, mcil_pkg::OFS_HCFG, 32'h15d);
    // homing with slot and timing inputs in use
    pins.slot <= 1'h1;
    pins.tim  <= 1'h1;
    dly       <= 8'h28;
    pins.home <= 1'h1;
    wcmd(mcil_pkg::CMD_HOME, 9'h000, 9'h000);
    repeat (3) @(posedge clk);
    chk("slot_use", 128'(1'h1), 128'(slot_use));
    chk("tim_use", 128'(1'h1), 128'(tim_use));
    chk("origin", 128'(1'h0), 128'(origin_ok));
    pins.home <= 1'h0;
    till_done();
    chk("origin", 128'(1'h1), 128'(origin_ok));
    chk("slot_use", 128'(1'h0), 128'(slot_use));
    // continuous runs: speed change, re-acceleration, both inputs
    s = seed[5:0];
    pins.sel <= s;
    pins.forward_run <= 1'h1;
    wcmd(mcil_pkg::CMD_RUN, 9'h1fc, {1'h1, s, 2'h0});
    s = ~s;
    pins.sel <= s;
    wcmd(mcil_pkg::CMD_RUN, 9'h0fc, {1'h0, s, 2'h0});
    pins.forward_run <= 1'h0;
    wcmd(mcil_pkg::CMD_DECEL, 9'h000, 9'h000);
    pins.forward_run <= 1'h1;
    wcmd(mcil_pkg::CMD_RUN, 9'h100, 9'h100);
    pins.rev <= 1'h1;
    wcmd(mcil_pkg::CMD_DECEL, 9'h000, 9'h000);
    pins.forward_run <= 1'h0;
    pins.rev <= 1'h0;
    till_done();
    pins.rev <= 1'h1;
    wcmd(mcil_pkg::CMD_RUN, 9'h100, 9'h000);
    pins.rev <= 1'h0;
    till_done();
    // inch moves, positive then negative
    for (int d = 1; d >= 0; d--)
    begin
      pins.pinch <= d[0];
      pins.minch <= !d[0];
      wcmd(mcil_pkg::CMD_INCH, 9'h100, {d[0], 8'h00});
      pins.pinch <= 1'h0;
      pins.minch <= 1'h0;
      till_done();
    end
    // stop during a positioning move, every stop action
    for (int a = 0; a < 4; a++)
    begin
      apb(1'h1, mcil_pkg::OFS_HCFG, 32'h105 | 32'(a << 6));
      pins.dstart[1] <= 1'h1;
      wcmd(mcil_pkg::CMD_POS, 9'h000, 9'h000);
      pins.stop <= 1'h1;
      wcmd(mcil_pkg::CMD_STOP, 9'h003, 9'(a));
      pins.dstart[1] <= 1'h0;
      pins.stop <= 1'h0;
      till_done();
      if (a > 1)
      begin
        chk("excite", 128'(1'h0), 128'(excite));
        pins.exc <= 1'h0;
        repeat (6) @(posedge clk);
        pins.exc <= 1'h1;
        repeat (8) @(posedge clk);
      end
    end
    final_report();
  end
endmodule
